// file: include/prbsc_pkg.sv
// Contract
// - no pattern generation at eighth transmit rate
// - every test starts with device reset
// - reference select pins driven before configuration
// - cdr threshold 01, multiplier 00 first
// - application serial fields set before lock
// - poll pll lock bit until high
// - pulse receiver enable zero then one
// - wait gain lock, retune cdr, poll
// - datapath_soft_reset after cdr retune
// - discard first counter read, then check zero
// - pin mode writes select only for shorter
// - serial outputs cabled back to inputs
// - one test type; change restarts procedure
`default_nettype none
package prbsc_pkg;
   // ----------------------------------------------------------------
   // device register map (word index, bit positions)
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_GLOBAL      = 5'h00;
   localparam logic [4:0] REG_CHAN_CTRL1  = 5'h01;
   localparam logic [4:0] REG_CHAN_CTRL2  = 5'h02;
   localparam logic [4:0] REG_DP_CTRL     = 5'h04;
   localparam logic [4:0] REG_STATUS      = 5'h05;
   localparam logic [4:0] REG_TEST_CTRL   = 5'h07;
   localparam logic [4:0] REG_SERDES_CFG  = 5'h08;
   localparam logic [4:0] REG_ERR_COUNT   = 5'h0e;
   localparam logic [4:0] REG_RX_CTRL     = 5'h14;
   localparam int         BIT_SOFT_RESET  = 15;
   localparam int         BIT_PLL_LOCK    = 0;
   localparam int         BIT_GAIN_LOCK   = 13;
   localparam int         BIT_GEN_EN      = 13;
   localparam int         BIT_CHECK_EN    = 12;
   localparam int         BIT_DP_RESET    = 3;
   localparam int         BIT_RX_EN       = 2;
   localparam logic [1:0] CDR_THR_INIT    = 2'h1;
   localparam logic [1:0] CDR_MULT_INIT   = 2'h0;
   localparam logic [1:0] CDR_MULT_FINAL  = 2'h1;
   localparam logic [1:0] RATE_EIGHTH     = 2'h3;
   localparam logic [2:0] SEL_PRBS7       = 3'h5;
   localparam logic [2:0] SEL_PRBS23      = 3'h6;
   localparam logic [2:0] SEL_PRBS31      = 3'h7;
   localparam logic [15:0] ERR_NONE       = 16'h0000;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int    CLK_PERIOD_NS   = 25;
   localparam int    RST_HOLD_NS     = 1000;
   localparam int    RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam longint AGC_WAIT_UI    = 250_000_000;
   localparam longint UI_PS          = 160;
   localparam longint AGC_WAIT_CYC_DEF = (AGC_WAIT_UI * UI_PS) / (1000 * CLK_PERIOD_NS);
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PAT_7 = 2'h0, PAT_23 = 2'h1, PAT_31 = 2'h2} prbsc_pat_t;
   typedef struct packed {
      logic       chan;
      logic       pin_mode;
      logic       hard_reset;
      logic       refsrc_a;
      logic       refsrc_b;
      logic [1:0] pat;
      logic [1:0] rate_tx;
      logic [1:0] rate_rx;
      logic [3:0] pll_multiplier;
      logic [1:0] pll_loop_bw;
      logic [4:0] post_tap_weight;
      logic [3:0] pre_tap_weight;
      logic [3:0] swing;
      logic [2:0] rx_equalizer_preset;
   } prbsc_cfg_t;
   typedef struct packed {
      logic        wr;
      logic        chan;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } prbsc_cmd_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_RST = 4'h1, ST_CFG1 = 4'h3, ST_CFG2 = 4'h2,
      ST_CFG8 = 4'h6, ST_PLL = 4'h7, ST_RXOFF = 4'h5, ST_RXON = 4'h4,
      ST_SEL = 4'hc, ST_GEN = 4'hd, ST_AGCW = 4'hf, ST_CDR2 = 4'he,
      ST_AGC = 4'ha, ST_DPRST = 4'hb, ST_VER = 4'h9, ST_RUN = 4'h8
   } prbsc_state_t;
endpackage
`default_nettype wire

// file: hdl/prbsc_mgmt.sv
`default_nettype none
// ----------------------------------------------------------------
// register access engine: holds one request until the device acks
// ----------------------------------------------------------------
module prbsc_mgmt
   import prbsc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        go,
   input  wire prbsc_cmd_t  cmd,
   input  wire logic        mgmt_ack,
   input  wire logic [15:0] mgmt_rdata,
   output var  logic        mgmt_req,
   output var  prbsc_cmd_t  mgmt_cmd,
   output var  logic        done,
   output var  logic [15:0] rdata
);
   typedef struct packed {
      logic        req;
      prbsc_cmd_t  cmd;
      logic        done;
      logic [15:0] rdata;
   } prbsc_mst_t;

   prbsc_mst_t st_ff;
   prbsc_mst_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      if (st_ff.req && mgmt_ack) begin
         nxt_st.req   = 1'b0;
         nxt_st.done  = 1'b1;
         nxt_st.rdata = mgmt_rdata;
      end else if (!st_ff.req && go) begin
         // a go while busy is dropped; the sequencer never issues one
         nxt_st.req = 1'b1;
         nxt_st.cmd = cmd;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mgmt_req = st_ff.req;
   assign mgmt_cmd = st_ff.cmd;
   assign done     = st_ff.done;
   assign rdata    = st_ff.rdata;

   req_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      mgmt_req && !mgmt_ack |=> mgmt_req && $stable(mgmt_cmd))
      else $error("request dropped before ack");
endmodule
`default_nettype wire

// file: hdl/prbsc_ctrl.sv
`default_nettype none
module prbsc_ctrl
   import prbsc_pkg::*;
#(
   parameter int unsigned AGC_WAIT_CYC = 32'(AGC_WAIT_CYC_DEF)
)(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire prbsc_cfg_t  cfg,
   input  wire logic        read_req,
   input  wire logic        mgmt_ack,
   input  wire logic [15:0] mgmt_rdata,
   input  wire logic        chan_a_check_ok,
   input  wire logic        chan_b_check_ok,
   output var  logic        mgmt_req,
   output var  prbsc_cmd_t  mgmt_cmd,
   output var  logic        dev_nrst_pin,
   output var  logic        chan_a_refsrc_pin,
   output var  logic        chan_b_refsrc_pin,
   output var  logic        pin_test_enable,
   output var  logic        busy,
   output var  logic        running,
   output var  logic        cfg_err,
   output var  logic        check_fail,
   output var  logic        count_valid,
   output var  logic [15:0] err_count,
   output var  logic        err_free
);
   typedef struct packed {
      prbsc_state_t state;
      prbsc_cfg_t   cfg;
      prbsc_cmd_t   cmd;
      logic         go;
      logic         issued;
      logic [31:0]  cnt;
      logic         dev_nrst;
      logic         refa;
      logic         refb;
      logic         pin_en;
      logic         err;
      logic         fail;
      logic         first;
      logic         cval;
      logic [15:0]  ecnt;
      logic         efree;
      logic         busy;
      logic         run;
   } prbsc_st_t;

   prbsc_st_t   st_ff;
   prbsc_st_t   nxt_st;
   prbsc_cmd_t  cmd_now;
   logic        acc_done;
   logic [15:0] acc_rdata;
   logic [2:0]  sel_code;
   logic        chan_ok;

   // ----------------------------------------------------------------
   // register access for the current step
   // ----------------------------------------------------------------
   always_comb begin
      unique case (st_ff.cfg.pat)
         PAT_7:   sel_code = SEL_PRBS7;
         PAT_23:  sel_code = SEL_PRBS23;
         default: sel_code = SEL_PRBS31;
      endcase
      cmd_now      = '0;
      cmd_now.chan = st_ff.cfg.chan;
      cmd_now.wr   = 1'b1;
      unique case (st_ff.state)
         ST_RST: begin
            cmd_now.addr = REG_GLOBAL;
            cmd_now.wdata[BIT_SOFT_RESET] = 1'b1;
         end
         ST_CFG1: begin
            cmd_now.addr  = REG_CHAN_CTRL1;
            cmd_now.wdata = {6'h00, st_ff.cfg.pll_loop_bw, st_ff.cfg.rate_tx,
                             st_ff.cfg.rate_rx, st_ff.cfg.pll_multiplier};
         end
         ST_CFG2: begin
            cmd_now.addr  = REG_CHAN_CTRL2;
            cmd_now.wdata = {3'h0, st_ff.cfg.post_tap_weight,
                             st_ff.cfg.pre_tap_weight, st_ff.cfg.swing};
         end
         ST_CFG8: begin
            cmd_now.addr  = REG_SERDES_CFG;
            cmd_now.wdata = {1'b0, st_ff.cfg.rx_equalizer_preset,
                             CDR_THR_INIT, CDR_MULT_INIT, 8'h00};
         end
         ST_CDR2: begin
            cmd_now.addr  = REG_SERDES_CFG;
            cmd_now.wdata = {1'b0, st_ff.cfg.rx_equalizer_preset,
                             CDR_THR_INIT, CDR_MULT_FINAL, 8'h00};
         end
         ST_RXON: begin
            cmd_now.addr = REG_RX_CTRL;
            cmd_now.wdata[BIT_RX_EN] = 1'b1;
         end
         ST_RXOFF: begin
            cmd_now.addr = REG_RX_CTRL;
         end
         ST_SEL, ST_GEN, ST_VER: begin
            cmd_now.addr = REG_TEST_CTRL;
            cmd_now.wdata[10:8] = sel_code;
            cmd_now.wdata[BIT_GEN_EN] = (st_ff.state != ST_SEL);
            cmd_now.wdata[BIT_CHECK_EN] = (st_ff.state == ST_VER);
         end
         ST_DPRST: begin
            cmd_now.addr = REG_DP_CTRL;
            cmd_now.wdata[BIT_DP_RESET] = 1'b1;
         end
         ST_PLL, ST_AGCW, ST_AGC: begin
            cmd_now.wr   = 1'b0;
            cmd_now.addr = REG_STATUS;
         end
         ST_RUN: begin
            cmd_now.wr   = 1'b0;
            cmd_now.addr = REG_ERR_COUNT;
         end
         ST_IDLE: begin
            cmd_now.wr = 1'b0;
         end
      endcase
   end

   assign chan_ok = st_ff.cfg.chan ? chan_b_check_ok : chan_a_check_ok;

   // ----------------------------------------------------------------
   // bring-up sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.go   = 1'b0;
      nxt_st.cval = 1'b0;
      // one access at a time: issue once, then reissue or advance on its completion
      if (st_ff.state != ST_IDLE && !st_ff.issued && st_ff.state != ST_RUN &&
          !(st_ff.state == ST_RST && st_ff.cfg.hard_reset)) begin
         nxt_st.go     = 1'b1;
         nxt_st.issued = 1'b1;
         nxt_st.cmd    = cmd_now;
      end
      if (acc_done) begin
         nxt_st.issued = 1'b0;
      end
      unique case (st_ff.state)
         ST_IDLE: begin
            if (start) begin
               if (cfg.rate_tx == RATE_EIGHTH) begin
                  nxt_st.err = 1'b1;
               end else begin
                  nxt_st.err    = 1'b0;
                  nxt_st.cfg    = cfg;
                  nxt_st.refa   = cfg.refsrc_a;
                  nxt_st.refb   = cfg.refsrc_b;
                  nxt_st.pin_en = cfg.pin_mode;
                  nxt_st.fail   = 1'b0;
                  nxt_st.first  = 1'b1;
                  nxt_st.efree  = 1'b0;
                  nxt_st.cnt    = '0;
                  nxt_st.state  = ST_RST;
               end
            end
         end
         ST_RST: begin
            if (st_ff.cfg.hard_reset) begin
               // hold the pin low, then give the device the same time to settle
               nxt_st.cnt      = st_ff.cnt + 32'h1;
               nxt_st.dev_nrst = (st_ff.cnt >= 32'(RST_HOLD_CYC));
               if (st_ff.cnt == 32'(2 * RST_HOLD_CYC - 1)) begin
                  nxt_st.state = ST_CFG1;
               end
            end else if (acc_done) begin
               nxt_st.state = ST_CFG1;
            end
         end
         ST_CFG1: if (acc_done) nxt_st.state = ST_CFG2;
         ST_CFG2: if (acc_done) nxt_st.state = ST_CFG8;
         ST_CFG8: if (acc_done) nxt_st.state = ST_PLL;
         ST_PLL: begin
            if (acc_done && acc_rdata[BIT_PLL_LOCK]) begin
               nxt_st.state = ST_RXOFF;
            end
         end
         ST_RXOFF: if (acc_done) nxt_st.state = ST_RXON;
         ST_RXON: begin
            if (acc_done) begin
               nxt_st.cnt = '0;
               // pin mode skips the select write for the default pattern
               if (st_ff.pin_en && sel_code == SEL_PRBS31) begin
                  nxt_st.state = ST_AGCW;
               end else begin
                  nxt_st.state = ST_SEL;
               end
            end
         end
         ST_SEL: if (acc_done) nxt_st.state = st_ff.pin_en ? ST_AGCW : ST_GEN;
         ST_GEN: if (acc_done) nxt_st.state = ST_AGCW;
         ST_AGCW: begin
            if (st_ff.cnt < AGC_WAIT_CYC) begin
               nxt_st.cnt = st_ff.cnt + 32'h1;
            end
            if (acc_done && (acc_rdata[BIT_GAIN_LOCK] || st_ff.cnt >= AGC_WAIT_CYC)) begin
               nxt_st.state = ST_CDR2;
            end
         end
         ST_CDR2: if (acc_done) nxt_st.state = ST_AGC;
         ST_AGC: begin
            if (acc_done && acc_rdata[BIT_GAIN_LOCK]) begin
               nxt_st.state = ST_DPRST;
            end
         end
         ST_DPRST: if (acc_done) nxt_st.state = st_ff.pin_en ? ST_RUN : ST_VER;
         ST_VER: if (acc_done) nxt_st.state = ST_RUN;
         ST_RUN: begin
            if (!chan_ok) begin
               nxt_st.fail = 1'b1;
            end
            if (acc_done) begin
               if (st_ff.first) begin
                  nxt_st.first = 1'b0;
               end else begin
                  nxt_st.cval  = 1'b1;
                  nxt_st.ecnt  = acc_rdata;
                  nxt_st.efree = (acc_rdata == ERR_NONE);
               end
            end
            if (!st_ff.issued && !acc_done) begin
               if (start) begin
                  // a start ends the test and returns to idle; the next start reruns the whole procedure
                  nxt_st.state  = ST_IDLE;
                  nxt_st.pin_en = 1'b0;
               end else if (read_req) begin
                  nxt_st.go     = 1'b1;
                  nxt_st.issued = 1'b1;
                  nxt_st.cmd    = cmd_now;
               end
            end
         end
      endcase
      // status outputs decoded ahead so they leave straight from flops
      nxt_st.busy = (nxt_st.state != ST_IDLE) && (nxt_st.state != ST_RUN);
      nxt_st.run  = (nxt_st.state == ST_RUN);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_ff          <= '0;
         st_ff.state    <= ST_IDLE;
         st_ff.dev_nrst <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   prbsc_mgmt u_mgmt (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .go         (st_ff.go),
      .cmd        (st_ff.cmd),
      .mgmt_ack   (mgmt_ack),
      .mgmt_rdata (mgmt_rdata),
      .mgmt_req   (mgmt_req),
      .mgmt_cmd   (mgmt_cmd),
      .done       (acc_done),
      .rdata      (acc_rdata)
   );

   assign dev_nrst_pin      = st_ff.dev_nrst;
   assign chan_a_refsrc_pin = st_ff.refa;
   assign chan_b_refsrc_pin = st_ff.refb;
   assign pin_test_enable   = st_ff.pin_en;
   assign busy              = st_ff.busy;
   assign running           = st_ff.run;
   assign cfg_err           = st_ff.err;
   assign check_fail        = st_ff.fail;
   assign count_valid       = st_ff.cval;
   assign err_count         = st_ff.ecnt;
   assign err_free          = st_ff.efree;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence rx_off_done_s;
      st_ff.state == ST_RXOFF && acc_done;
   endsequence
   sequence rx_on_write_s;
      mgmt_req && mgmt_cmd.addr == REG_RX_CTRL && mgmt_cmd.wdata[BIT_RX_EN];
   endsequence

   eighth_refused_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state == ST_IDLE && start && cfg.rate_tx == RATE_EIGHTH
      |=> cfg_err && st_ff.state == ST_IDLE)
      else $error("eighth rate start not refused");
   hard_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state == ST_IDLE && start && cfg.hard_reset && cfg.rate_tx != RATE_EIGHTH
      |=> ##1 !dev_nrst_pin [*8])
      else $error("hard reset pulse missing");
   refsrc_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state != ST_IDLE && $past(st_ff.state) != ST_IDLE
      |-> $stable(chan_a_refsrc_pin) && $stable(chan_b_refsrc_pin))
      else $error("reference select changed during test");
   cdr_init_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state == ST_CFG8 && mgmt_req |-> mgmt_cmd.wdata[11:8] == 4'h4)
      else $error("initial cdr fields wrong");
   pll_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state == ST_PLL && acc_done && !acc_rdata[BIT_PLL_LOCK]
      |=> st_ff.state == ST_PLL)
      else $error("left pll poll without lock");
   rx_toggle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      rx_off_done_s |=> ##2 rx_on_write_s)
      else $error("receiver enable not re-set");
   sel_code_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      mgmt_req && mgmt_cmd.addr == REG_TEST_CTRL && st_ff.cfg.pat == PAT_7
      |-> mgmt_cmd.wdata[10:8] == 3'h5)
      else $error("wrong pattern select code");
   cdr_final_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state == ST_CDR2 && mgmt_req |-> mgmt_cmd.wdata[9:8] == 2'h1)
      else $error("final cdr multiplier wrong");
   dp_before_run_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff.state == ST_RUN && $past(st_ff.state) != ST_RUN
      |-> $past(st_ff.state) == ST_VER || $past(st_ff.state) == ST_DPRST)
      else $error("run entered without datapath_soft_reset");
   pin_skip_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      pin_test_enable |-> st_ff.state != ST_GEN && st_ff.state != ST_VER)
      else $error("enable write issued in pin mode");
   fail_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      running && !chan_ok |=> check_fail)
      else $error("pass low not latched");
   discard_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      running && st_ff.first && acc_done |=> !count_valid)
      else $error("first counter read not discarded");
endmodule
`default_nettype wire

// file: tb/prbsc_dev_model.sv
`default_nettype none
// ----------------------------------------------------------------
// device stand-in: registers, lock status, pass pins, error counter
// ----------------------------------------------------------------
module prbsc_dev_model
   import prbsc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        dev_nrst_pin,
   input  wire logic        pin_test_enable,
   input  wire logic        mgmt_req,
   input  wire prbsc_cmd_t  mgmt_cmd,
   output var  logic        mgmt_ack,
   output var  logic [15:0] mgmt_rdata,
   output var  logic        chan_a_check_ok,
   output var  logic        chan_b_check_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   int          ack_dly = 0;
   int          wt = 0;
   int          polls = 0;
   logic [1:0]  bad = 2'h0;
   logic [1:0]  chk = 2'h0;
   logic [1:0]  eighth = 2'h0;
   logic        gain = 1'b0;
   logic [2:0]  sel [2] = '{3'h0, 3'h0};
   logic [15:0] errc [2] = '{16'h0, 16'h0};
   initial mgmt_ack = 1'b0;
   initial mgmt_rdata = 16'h0;
   // pass pins stand for the looped-back self-synchronising checker
   assign chan_a_check_ok = !bad[0];
   assign chan_b_check_ok = !bad[1];
   function automatic logic [2:0] pat_of(input logic ch);
      return (pin_test_enable && sel[ch] == 3'h0) ? SEL_PRBS31 : sel[ch];
   endfunction
   task automatic wipe();
      polls = 0;
      gain = 1'b0;
      chk = 2'h0;
      eighth = 2'h0;
      sel = '{3'h0, 3'h0};
      errc = '{16'h0, 16'h0};
   endtask
   task automatic inject(input logic ch, input int n);
      int t;
      t = int'(errc[ch]) + n;
      if (chk[ch]) errc[ch] = (t > 65535) ? 16'hffff : 16'(t);
   endtask
   // released read bus is inverted the cycle after every ack, reads and writes alike
   always @(posedge clk_sys) begin
      logic [15:0] w;
      logic        ch;
      w = mgmt_cmd.wdata;
      ch = mgmt_cmd.chan;
      mgmt_ack <= 1'b0;
      if (mgmt_ack) mgmt_rdata <= ~mgmt_rdata;
      if (!dev_nrst_pin) wipe();
      else if (mgmt_req && !mgmt_ack && wt < ack_dly) wt++;
      else if (mgmt_req && !mgmt_ack) begin
         wt = 0;
         mgmt_ack <= 1'b1;
         if (mgmt_cmd.wr) case (mgmt_cmd.addr)
            REG_GLOBAL:     if (w[BIT_SOFT_RESET]) wipe();
            REG_CHAN_CTRL1: eighth[ch] = (w[7:6] == RATE_EIGHTH);
            REG_SERDES_CFG: gain = (w[9:8] == CDR_MULT_FINAL);
            REG_DP_CTRL:    if (w[BIT_DP_RESET] && pin_test_enable) chk[ch] = !eighth[ch];
            REG_TEST_CTRL: begin
               sel[ch] = w[10:8];
               chk[ch] = w[BIT_CHECK_EN] && !eighth[ch];
            end
            default: ;
         endcase
         else if (mgmt_cmd.addr == REG_STATUS) begin
            polls++;
            mgmt_rdata <= {2'h0, gain, 12'h0, polls > 2};
         end else if (mgmt_cmd.addr == REG_ERR_COUNT) begin
            mgmt_rdata <= errc[ch];
            errc[ch] = 16'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_prbs_pattern_test_control.sv
`default_nettype none
module tb_prbs_pattern_test_control import prbsc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        start = 1'b0;
   logic        read_req = 1'b0;
   logic        saw_hrst = 1'b0;
   logic        ch_sel = 1'b0;
   prbsc_cfg_t  cfg = '0;
   logic        mgmt_ack, mgmt_req, dev_nrst_pin, ra_pin, rb_pin, pin_en, busy;
   logic        running, cfg_err, check_fail, count_valid, err_free, ok_a, ok_b;
   logic [15:0] mgmt_rdata, err_count;
   prbsc_cmd_t  mgmt_cmd;
   int          n_errors = 0;
   int          total_checks = 0;
   logic [21:0] wq [$];
   logic [15:0] cq [$];
   prbsc_ctrl #(.AGC_WAIT_CYC(20)) i_dut (
      .clk_sys(clk_sys), .nrst(nrst), .start(start), .cfg(cfg), .read_req(read_req),
      .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .chan_a_check_ok(ok_a),
      .chan_b_check_ok(ok_b), .mgmt_req(mgmt_req), .mgmt_cmd(mgmt_cmd),
      .dev_nrst_pin(dev_nrst_pin), .chan_a_refsrc_pin(ra_pin), .chan_b_refsrc_pin(rb_pin),
      .pin_test_enable(pin_en), .busy(busy), .running(running), .cfg_err(cfg_err),
      .check_fail(check_fail), .count_valid(count_valid), .err_count(err_count),
      .err_free(err_free));
   prbsc_dev_model i_dev (
      .clk_sys(clk_sys), .dev_nrst_pin(dev_nrst_pin), .pin_test_enable(pin_en),
      .mgmt_req(mgmt_req), .mgmt_cmd(mgmt_cmd), .mgmt_ack(mgmt_ack),
      .mgmt_rdata(mgmt_rdata), .chan_a_check_ok(ok_a), .chan_b_check_ok(ok_b));
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic cmp(input logic [21:0] g, input logic [21:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_wr(input logic [21:0] g, input logic [21:0] e); cmp(g, e); endtask
   task automatic cmp_cnt(input logic [15:0] g, input logic [15:0] e); cmp(22'(g), 22'(e)); endtask
   task automatic cmp_flag(input logic g, input logic e); cmp(22'(g), 22'(e)); endtask
   task automatic tk(input int n); repeat (n) @(posedge clk_sys); #1; endtask
   task automatic push(input logic [4:0] a, input logic [15:0] d); wq.push_back({ch_sel, a, d}); endtask
   task automatic pulse_start(); start = 1'b1; tk(1); start = 1'b0; tk(1); endtask
   // ----------------------------------------------------------------
   // result watcher: device writes and counter reports against notes
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      logic [21:0] g;
      logic [21:0] w;
      logic [15:0] e;
      if (!dev_nrst_pin) saw_hrst <= 1'b1;
      if (mgmt_req && mgmt_ack && mgmt_cmd.wr) begin
         g = {mgmt_cmd.chan, mgmt_cmd.addr, mgmt_cmd.wdata};
         w = wq.size() ? wq.pop_front() : 22'h3fffff;
         cmp_wr(g, w);
      end
      if (count_valid) begin
         e = cq.size() ? cq.pop_front() : 16'hdead;
         cmp_cnt(err_count, e);
         cmp_flag(err_free, e == ERR_NONE);
      end
   end
   // first read of a test is discarded by the design, so no note is kept
   task automatic rd(input logic keep, input logic [15:0] e);
      if (keep) cq.push_back(e);
      read_req = 1'b1;
      tk(1);
      read_req = 1'b0;
      for (int i = 0; i < 50 && mgmt_req !== 1'b1; i++) tk(1);
      for (int i = 0; i < 50 && mgmt_req === 1'b1; i++) tk(1);
      tk(3);
   endtask
   task automatic run_test(input int t);
      prbsc_cfg_t c;
      logic [2:0] s;
      c = prbsc_cfg_t'(33'({$urandom, $urandom}));
      c.pin_mode = (t > 2);
      c.pat = (t == 6) ? 2'h3 : 2'(t % 3);
      c.hard_reset = t[0];
      c.chan = t[1];
      c.rate_tx = 2'($urandom_range(2));
      ch_sel = c.chan;
      s = (c.pat == 2'h0) ? SEL_PRBS7 : (c.pat == 2'h1) ? SEL_PRBS23 : SEL_PRBS31;
      i_dev.ack_dly = t % 4;
      if (!c.hard_reset) push(REG_GLOBAL, 16'h8000);
      push(REG_CHAN_CTRL1, {6'h0, c.pll_loop_bw, c.rate_tx, c.rate_rx, c.pll_multiplier});
      push(REG_CHAN_CTRL2, {3'h0, c.post_tap_weight, c.pre_tap_weight, c.swing});
      push(REG_SERDES_CFG, {1'h0, c.rx_equalizer_preset, CDR_THR_INIT, CDR_MULT_INIT, 8'h0});
      push(REG_RX_CTRL, 16'h0000);
      push(REG_RX_CTRL, 16'h0004);
      if (!c.pin_mode || s != SEL_PRBS31) push(REG_TEST_CTRL, {5'h00, s, 8'h00});
      if (!c.pin_mode) push(REG_TEST_CTRL, {5'h04, s, 8'h00});
      push(REG_SERDES_CFG, {1'h0, c.rx_equalizer_preset, CDR_THR_INIT, CDR_MULT_FINAL, 8'h0});
      push(REG_DP_CTRL, 16'h0008);
      if (!c.pin_mode) push(REG_TEST_CTRL, {5'h06, s, 8'h00});
      cfg = c;
      saw_hrst = 1'b0;
      pulse_start();
      for (int i = 0; i < 3000 && running !== 1'b1; i++) tk(1);
      cmp_flag(running, 1'b1);
      cmp_cnt(16'(wq.size()), 16'h0000);
      cmp_flag(cfg_err, 1'b0);
      cmp_flag(check_fail, 1'b0);
      cmp_flag(saw_hrst, c.hard_reset);
      cmp_flag(pin_en, c.pin_mode);
      cmp_flag(c.chan ? rb_pin : ra_pin, c.chan ? c.refsrc_b : c.refsrc_a);
      cmp_cnt(16'(i_dev.pat_of(c.chan)), 16'(s));
      rd(1'b0, ERR_NONE);
      rd(1'b1, ERR_NONE);
      i_dev.inject(c.chan, 5);
      i_dev.bad[c.chan] = 1'b1;
      tk(3);
      cmp_flag(check_fail, 1'b1);
      i_dev.bad = 2'h0;
      rd(1'b1, 16'h0005);
      rd(1'b1, ERR_NONE);
      i_dev.inject(c.chan, 70000);
      rd(1'b1, 16'hffff);
      pulse_start();
      tk(3);
      cmp_flag(running, 1'b0);
      $display("test %0d done, mismatches so far %0d", t, n_errors);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(27));
      tk(19);
      cmp_flag(mgmt_req, 1'b0);
      cmp_flag(dev_nrst_pin, 1'b1);
      tk(1);
      nrst = 1'b1;
      cfg = prbsc_cfg_t'(33'($urandom));
      cfg.rate_tx = RATE_EIGHTH;
      pulse_start();
      tk(3);
      cmp_flag(cfg_err, 1'b1);
      cmp_flag(busy, 1'b0);
      for (int t = 0; t < 7; t++) run_test(t);
      summarize();
   end
   initial begin
      #(25 * 40000);
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
